// ===== rtl/ppr_pkg.sv
package ppr_pkg;
  localparam int unsigned CLK_NS = 25;
  localparam logic [15:0] DATA_ADR = 16'h0378;
  localparam logic [15:0] STAT_ADR = 16'h0379;
  localparam logic [15:0] CTRL_ADR = 16'h037A;
  localparam int ST_BUSY = 7;
  localparam int ST_ACK = 6;
  localparam int ST_PAPER = 5;
  localparam int ST_SEL = 4;
  localparam int ST_ERR = 3;
  localparam int ST_TMO = 0;
  localparam logic [1:0] STAT_RSV = 2'h3;
  localparam int CT_DIR = 5;
  localparam int CT_IEN = 4;
  localparam int CT_SEL = 3;
  localparam int CT_INIT = 2;
  localparam int CT_AFD = 1;
  localparam int CT_STB = 0;
  localparam logic [7:0] CTRL_WMASK = 8'h3F;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam int unsigned STB_NS = 500;
  localparam int unsigned TMO_NS = 10000;
  localparam int unsigned STB_CYC = (STB_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned TMO_CYC = TMO_NS / CLK_NS;
  localparam int unsigned FIFO_DEPTH = 8;
  localparam int unsigned CNT_W = 16;

  typedef struct packed {
    logic busy;
    logic ack_n;
    logic paper_out;
    logic selected;
    logic fault_n;
  } ppr_prn_s;

  typedef struct packed {
    logic [15:0] addr;
    logic rd;
    logic wr;
    logic [7:0] wdata;
  } ppr_io_s;

  typedef enum logic [1:0] {
    ENG_IDLE = 2'h0,
    ENG_STROBE = 2'h1,
    ENG_WAIT = 2'h3
  } ppr_eng_e;
endpackage : ppr_pkg

// ===== rtl/ppr_port.sv
// How it works
// - Status bits 7,6: busy, acknowledge, active low
// - Status bit 5 reads paper out
// - Status bit 4 reads printer selected
// - Status bit 3 low on printer error
// - Status bits 2-1 always read 11
// - Status bit 0 flags handshake timeout
// - Control bits 7-6 held at 00
// - Control bit 5 sets data direction
// - Control bit 4 gates interrupt request
// - Data read/write; status write ignored
`timescale 1ns/1ps
module ppr_fifo #(
  parameter int unsigned W = 8,
  parameter int unsigned D = 8
) (
  input wire logic i_mclk, // Clock
  input wire logic i_srst, // Sync reset
  input wire logic i_ce, // Clock enable
  input wire logic i_wvalid, // Push request
  output logic o_wready, // Not full
  input wire logic [W-1:0] i_wdata, // Push data
  output logic o_rvalid, // Not empty
  input wire logic i_rready, // Pop request
  output logic [W-1:0] o_rdata // Head word
);
  localparam int unsigned AW = (D > 1) ? $clog2(D) : 1;
  logic [W-1:0] mem [D];
  logic [AW-1:0] wptr_q;
  logic [AW-1:0] rptr_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p);
    nxt = (p == AW'(D - 1)) ? '0 : p + 1'b1;
  endfunction : nxt

  assign o_wready = (cnt_q != (AW + 1)'(D));
  assign o_rvalid = (cnt_q != '0);
  assign o_rdata = mem[rptr_q];
  assign push = i_ce && i_wvalid && o_wready;
  assign pop = i_ce && i_rready && o_rvalid;

  always_ff @(posedge i_mclk) begin
    if (push) begin
      mem[wptr_q] <= i_wdata;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      wptr_q <= '0;
      rptr_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wptr_q <= nxt(wptr_q);
      end
      if (pop) begin
        rptr_q <= nxt(rptr_q);
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule : ppr_fifo

module ppr_port #(
  parameter int unsigned FIFO_DEPTH = ppr_pkg::FIFO_DEPTH,
  parameter int unsigned STB_CYC = ppr_pkg::STB_CYC,
  parameter int unsigned TMO_CYC = ppr_pkg::TMO_CYC
) (
  input wire logic i_mclk, // 40 MHz clock
  input wire logic i_srst, // Sync reset, high
  input wire logic i_ce, // Clock enable
  input wire ppr_pkg::ppr_io_s i_io, // Host I/O cycle
  output logic [7:0] o_rdata, // Read data
  output logic o_rvalid, // Read data valid
  output logic o_wready, // Data write accepted
  input wire ppr_pkg::ppr_prn_s i_prn, // Printer status lines
  input wire logic [7:0] i_pd_in, // Data lines in
  output logic [7:0] o_pd_out, // Data lines out
  output logic o_pd_oe_n, // Data drive enable, low
  output logic o_strobe, // Strobe to printer
  output logic o_select, // Select printer
  output logic o_init_n, // Initialise, low
  output logic o_autofeed, // Auto line feed
  output logic o_irq // Interrupt request
);
  import ppr_pkg::*;

  logic [7:0] ctrl_q;
  logic [7:0] pd_q;
  logic [7:0] rdata_q;
  logic rvalid_q;
  logic tmo_q;
  logic irq_q;
  logic [CNT_W-1:0] cnt_q;
  ppr_eng_e eng_q;
  logic fifo_rvalid;
  logic [7:0] fifo_rdata;
  logic dir_in;
  logic rd_data;
  logic rd_stat;
  logic rd_ctrl;
  logic wr_data;
  logic wr_stat;
  logic wr_ctrl;
  logic pop;
  logic tmo_evt;
  logic [7:0] status;

  function automatic logic hit(input logic [15:0] a, input logic [15:0] loc);
    hit = (a == loc);
  endfunction : hit

  assign rd_data = i_ce && i_io.rd && hit(i_io.addr, DATA_ADR);
  assign rd_stat = i_ce && i_io.rd && hit(i_io.addr, STAT_ADR);
  assign rd_ctrl = i_ce && i_io.rd && hit(i_io.addr, CTRL_ADR);
  assign wr_data = i_ce && i_io.wr && hit(i_io.addr, DATA_ADR);
  assign wr_stat = i_ce && i_io.wr && hit(i_io.addr, STAT_ADR);
  assign wr_ctrl = i_ce && i_io.wr && hit(i_io.addr, CTRL_ADR);
  assign dir_in = ctrl_q[CT_DIR];

  // Status word assembled from live printer lines, reserved bits 11 and the registered timeout flag
  always_comb begin
    status = '0;
    status[ST_BUSY] = ~i_prn.busy;
    status[ST_ACK] = i_prn.ack_n;
    status[ST_PAPER] = i_prn.paper_out;
    status[ST_SEL] = i_prn.selected;
    status[ST_ERR] = i_prn.fault_n;
    status[ST_ERR-1:ST_TMO+1] = STAT_RSV;
    status[ST_TMO] = tmo_q;
  end

  ppr_fifo #(
    .W(8),
    .D(FIFO_DEPTH)
  ) u_fifo (
    .i_mclk(i_mclk),
    .i_srst(i_srst),
    .i_ce(i_ce),
    .i_wvalid(wr_data),
    .o_wready(o_wready),
    .i_wdata(i_io.wdata),
    .o_rvalid(fifo_rvalid),
    .i_rready(pop),
    .o_rdata(fifo_rdata)
  );

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      ctrl_q <= CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_q <= i_io.wdata & CTRL_WMASK;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      rdata_q <= '0;
      rvalid_q <= 1'b0;
    end else if (i_ce) begin
      rvalid_q <= i_io.rd;
      if (rd_data) begin
        rdata_q <= dir_in ? i_pd_in : pd_q;
      end else if (rd_stat) begin
        rdata_q <= status;
      end else if (rd_ctrl) begin
        rdata_q <= ctrl_q;
      end else if (i_io.rd) begin
        rdata_q <= '0;
      end
    end
  end

  // Byte handed to the printer: strobe, then wait for acknowledge
  assign pop = i_ce && (eng_q == ENG_IDLE) && fifo_rvalid && !dir_in;
  assign tmo_evt = i_ce && (eng_q == ENG_WAIT) && i_prn.ack_n && (cnt_q == '0);

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      eng_q <= ENG_IDLE;
      cnt_q <= '0;
    end else if (i_ce) begin
      unique case (eng_q)
        ENG_IDLE: begin
          if (pop) begin
            eng_q <= ENG_STROBE;
            cnt_q <= CNT_W'(STB_CYC - 1);
          end
        end
        ENG_STROBE: begin
          if (cnt_q == '0) begin
            eng_q <= ENG_WAIT;
            cnt_q <= CNT_W'(TMO_CYC - 1);
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        ENG_WAIT: begin
          if (!i_prn.ack_n || cnt_q == '0) begin
            eng_q <= ENG_IDLE;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        default: begin
          eng_q <= ENG_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      pd_q <= '0;
    end else if (pop) begin
      pd_q <= fifo_rdata;
    end
  end

  // timeout flag, set beats read clear
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      tmo_q <= 1'b0;
    end else if (tmo_evt) begin
      tmo_q <= 1'b1;
    end else if (rd_stat) begin
      tmo_q <= 1'b0;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      irq_q <= 1'b0;
    end else if (i_ce) begin
      irq_q <= ctrl_q[CT_IEN] && !i_prn.ack_n;
    end
  end

  assign o_rdata = rdata_q;
  assign o_rvalid = rvalid_q;
  assign o_pd_out = pd_q;
  assign o_pd_oe_n = dir_in;
  assign o_strobe = (eng_q == ENG_STROBE) || ctrl_q[CT_STB];
  assign o_select = ctrl_q[CT_SEL];
  assign o_init_n = ctrl_q[CT_INIT];
  assign o_autofeed = ctrl_q[CT_AFD];
  assign o_irq = irq_q;

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_srst);

  a_status_hand: assert property (rd_stat |=> o_rdata[ST_BUSY] == !$past(i_prn.busy)
    && o_rdata[ST_ACK] == $past(i_prn.ack_n)) else $error("busy/ack status wrong");
  a_status_paper: assert property (rd_stat |=> o_rdata[ST_PAPER] == $past(i_prn.paper_out))
    else $error("paper status wrong");
  a_status_sel: assert property (rd_stat |=> o_rdata[ST_SEL] == $past(i_prn.selected))
    else $error("select status wrong");
  a_status_err: assert property (rd_stat |=> o_rdata[ST_ERR] == $past(i_prn.fault_n))
    else $error("error status wrong");
  a_status_rsv: assert property (rd_stat |=> o_rdata[2:1] == 2'h3 && o_rvalid)
    else $error("reserved status bits not 11");
  a_tmo_flag: assert property (tmo_evt |=> tmo_q)
    else $error("timeout not flagged");
  a_tmo_read: assert property (rd_stat |=> o_rdata[ST_TMO] == $past(tmo_q))
    else $error("timeout bit misread");
  a_tmo_clear: assert property ((rd_stat && !tmo_evt) |=> !tmo_q)
    else $error("timeout not cleared by read");
  a_ctrl_rsv: assert property (rd_ctrl |=> o_rdata[7:6] == 2'h0)
    else $error("control reserved bits not 00");
  a_dir_oe: assert property (wr_ctrl |=> o_pd_oe_n == $past(i_io.wdata[CT_DIR]))
    else $error("direction not applied");
  a_irq_gate: assert property ((i_ce && !ctrl_q[CT_IEN]) |=> !o_irq)
    else $error("interrupt while disabled");
  a_sel_out: assert property (wr_ctrl |=> o_select == $past(i_io.wdata[CT_SEL]))
    else $error("select output wrong");
  a_stat_wr_ign: assert property ((wr_stat && !wr_ctrl && !tmo_evt) |=> $stable(ctrl_q)
    && tmo_q == ($past(tmo_q) && !$past(rd_stat))) else $error("status write had an effect");
  a_data_hold: assert property (pop |=> o_pd_out == $past(fifo_rdata) && o_strobe
    ##1 (o_pd_out == $past(o_pd_out, 1))) else $error("data byte not held");

  c_timeout: cover property (tmo_evt);
  c_ack_done: cover property (eng_q == ENG_WAIT && !i_prn.ack_n);
  c_fifo_full: cover property (!o_wready);
  c_read_in: cover property (rd_data && dir_in);
endmodule : ppr_port

// ===== verif/ppr_printer_model.sv
`timescale 1ns/1ps
module ppr_printer_model (
  input wire logic i_mclk, // Clock
  input wire logic i_srst, // Sync reset
  input wire logic i_strobe, // Strobe from port
  input wire logic [7:0] i_pd, // Port data out
  input wire logic i_pd_oe_n, // Port drive enable, low
  input wire logic [7:0] i_drive, // Byte this side drives
  input wire logic i_no_ack, // Withhold acknowledge
  input wire logic i_ack_hold, // Hold acknowledge low
  output logic o_ack_n, // Acknowledge, low
  output logic [7:0] o_wire, // Data line level
  output logic [7:0] o_last, // Last byte taken
  output logic [7:0] o_count // Bytes taken
);
  logic stb_q;
  logic [2:0] ack_cnt_q;
  // Line level follows whichever side drives
  assign o_wire = i_pd_oe_n ? i_drive : i_pd;
  assign o_ack_n = ~(i_ack_hold | (ack_cnt_q != 3'h0 && ack_cnt_q < 3'h3));
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      stb_q <= 1'b0;
      ack_cnt_q <= 3'h0;
      o_last <= 8'h00;
      o_count <= 8'h00;
    end else begin
      stb_q <= i_strobe;
      if (i_strobe && !stb_q) begin
        o_last <= i_pd;
        o_count <= o_count + 8'h01;
        if (!i_no_ack) begin
          ack_cnt_q <= 3'h5;
        end
      end else if (ack_cnt_q != 3'h0) begin
        ack_cnt_q <= ack_cnt_q - 3'h1;
      end
    end
  end
endmodule : ppr_printer_model

// ===== verif/ppr_port_tb_top.sv
`timescale 1ns/1ps
module ppr_port_tb_top;
  import ppr_pkg::*;
  localparam int unsigned STB = 2;
  localparam int unsigned TMO = 8;
  logic clk = 1'b0;
  logic srst = 1'b1;
  ppr_io_s io = '0;
  ppr_prn_s prn;
  logic busy = 1'b0, paper = 1'b0, sel = 1'b1, fault_n = 1'b1, no_ack = 1'b0, ack_hold = 1'b0;
  logic ce = 1'b1;
  logic [7:0] drive = 8'h00;
  logic [7:0] rdata, pd_out, pd_wire, last, count, base;
  logic rvalid, wready, oe_n, strobe, select, init_n, autofeed, irq, ack_n;
  int errors = 0;
  int n_checks = 0;
  always #12.5 clk = ~clk;
  assign prn = {busy, ack_n, paper, sel, fault_n};
  ppr_port #(.FIFO_DEPTH(8), .STB_CYC(STB), .TMO_CYC(TMO)) i_dut (.i_mclk(clk), .i_srst(srst), .i_ce(ce),
    .i_io(io), .o_rdata(rdata), .o_rvalid(rvalid), .o_wready(wready), .i_prn(prn), .i_pd_in(pd_wire),
    .o_pd_out(pd_out), .o_pd_oe_n(oe_n), .o_strobe(strobe), .o_select(select), .o_init_n(init_n),
    .o_autofeed(autofeed), .o_irq(irq));
  ppr_printer_model i_prt (.i_mclk(clk), .i_srst(srst), .i_strobe(strobe), .i_pd(pd_out), .i_pd_oe_n(oe_n),
    .i_drive(drive), .i_no_ack(no_ack), .i_ack_hold(ack_hold), .o_ack_n(ack_n), .o_wire(pd_wire),
    .o_last(last), .o_count(count));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t %s: got %h want %h", $time, what, seen, exp);
    end
  endtask : check
  task automatic results();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : results
  task automatic io_wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    io.addr = a;
    io.wdata = d;
    io.wr = 1'b1;
    @(negedge clk);
    io.wr = 1'b0;
  endtask : io_wr
  task automatic io_rd(input logic [15:0] a, input logic [7:0] exp, input string what);
    @(negedge clk);
    io.addr = a;
    io.rd = 1'b1;
    @(negedge clk);
    io.rd = 1'b0;
    check({7'h00, rvalid}, 8'h01, "read valid");
    check(rdata, exp, what);
  endtask : io_rd
  function automatic logic [7:0] stat(input logic tmo);
    return {~busy, ack_n, paper, sel, fault_n, STAT_RSV, tmo};
  endfunction : stat
  task automatic wait_byte(input logic [7:0] n);
    int k;
    k = 0;
    while (count !== n && k < 60) begin
      @(negedge clk);
      k++;
    end
    if (count !== n) begin
      errors++;
      $display("[FAIL] %0t byte wait timed out", $time);
      results();
    end
  endtask : wait_byte
  initial begin
    repeat (4) @(negedge clk);
    srst = 1'b0;
    io_rd(CTRL_ADR, CTRL_RST, "ctrl reset");
    for (int k = 0; k < 8; k++) begin
      busy = k[0];
      paper = k[1];
      fault_n = k[2];
      sel = ~k[2];
      io_rd(STAT_ADR, stat(1'b0), "status lines");
    end
    busy = 1'b0;
    paper = 1'b0;
    io_wr(STAT_ADR, 8'hFF);
    io_rd(STAT_ADR, stat(1'b0), "status write");
    io_rd(CTRL_ADR, CTRL_RST, "ctrl after status write");
    io_wr(CTRL_ADR, 8'hEE);
    io_rd(CTRL_ADR, 8'h2E, "ctrl reserved");
    check({4'h0, oe_n, select, init_n, autofeed}, 8'h0F, "ctrl pins");
    // Clock enable low must swallow the write
    ce = 1'b0;
    io_wr(CTRL_ADR, 8'h00);
    check({7'h00, select}, 8'h01, "ce freeze");
    ce = 1'b1;
    io_wr(CTRL_ADR, 8'h10);
    repeat (3) @(negedge clk);
    check({7'h00, irq}, 8'h00, "irq idle");
    ack_hold = 1'b1;
    repeat (3) @(negedge clk);
    check({7'h00, irq}, 8'h01, "irq on");
    io_wr(CTRL_ADR, 8'h00);
    repeat (3) @(negedge clk);
    check({7'h00, irq}, 8'h00, "irq masked");
    ack_hold = 1'b0;
    base = count;
    io_wr(DATA_ADR, 8'hA5);
    wait_byte(base + 8'h01);
    check(last, 8'hA5, "byte sent");
    check(pd_out, 8'hA5, "lines hold");
    io_rd(DATA_ADR, 8'hA5, "data read");
    repeat (10) @(negedge clk);
    io_wr(CTRL_ADR, 8'h20);
    drive = 8'h3C;
    io_rd(DATA_ADR, 8'h3C, "data in");
    check({7'h00, oe_n}, 8'h01, "released");
    base = count;
    for (int k = 0; k < 8; k++) begin
      io_wr(DATA_ADR, 8'h40 + 8'(k));
    end
    check({7'h00, wready}, 8'h00, "fifo full");
    io_wr(DATA_ADR, 8'hFF);
    io_wr(CTRL_ADR, 8'h00);
    for (int k = 0; k < 8; k++) begin
      wait_byte(base + 8'(k + 1));
      check(last, 8'h40 + 8'(k), "fifo order");
    end
    repeat (20) @(negedge clk);
    check(count, base + 8'h08, "drop when full");
    io_wr(CTRL_ADR, 8'h01);
    check({7'h00, strobe}, 8'h01, "ctrl strobe");
    io_wr(CTRL_ADR, 8'h00);
    check(count, base + 8'h09, "strobe byte");
    check(last, 8'h47, "lines held");
    repeat (10) @(negedge clk);
    no_ack = 1'b1;
    io_wr(DATA_ADR, 8'h11);
    repeat (STB + TMO + 10) @(negedge clk);
    io_rd(STAT_ADR, stat(1'b1), "timeout set");
    io_rd(STAT_ADR, stat(1'b0), "timeout clear");
    results();
  end
  initial begin
    repeat (100000) @(posedge clk);
    errors++;
    $display("[FAIL] %0t run timed out", $time);
    results();
  end
endmodule : ppr_port_tb_top
